/* shared/tbc_defines.vh */
// Register map, field positions, reset values and voltage scale
`ifndef TBC_DEFINES_VH
`define TBC_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TBC_ADDR_VSEL     8'h01
`define TBC_ADDR_CMD1     8'h03
`define TBC_ADDR_CMD2     8'h04
`define TBC_ADDR_CMD3     8'h05
`define TBC_ADDR_STATUS   8'h06

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define TBC_APPLY_BIT     7
`define TBC_CODE_MSB      6
`define TBC_SLEW_MSB      6
`define TBC_SLEW_LSB      4
`define TBC_MODE_BIT      1
`define TBC_DIS_N_BIT     0
`define TBC_REG_RESET     8'h00
`define TBC_GCALL_ADDR    7'h00
`define TBC_TENBIT_PFX    5'h1E

// ----------------------------------------------------------------
// Voltage scale in millivolts
// ----------------------------------------------------------------
`define TBC_VMIN_MV       680
`define TBC_VSTEP_MV      10

`endif

/* testbench/tbc_host_model.sv */
// Two-wire bus host model that drives the block's serial target port
`timescale 1ns/1ps
`default_nettype none
module tbc_host_model (
    input  wire logic       clk_in,    // System clock
    input  wire logic       sda_in,    // Resolved data line
    output var  logic       scl_out,   // Serial clock, high when idle
    output var  logic       sda_out,   // Data drive, one releases the line
    output var  logic       res_v_out, // Result strobe, one cycle
    output var  logic [7:0] res_d_out  // Ack seen or byte read
);
    // Bus starts idle with both lines released
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
        res_v_out = 1'b0;
        res_d_out = 8'h00;
    end
    // Third of a bit, long enough for the block's edge detection
    task automatic hp;
        repeat (4) @(posedge clk_in);
    endtask
    // Data moves while the clock is low, is sampled while it is high
    task automatic bit_io(input logic b, output logic s);
        sda_out <= b;
        hp;
        scl_out <= 1'b1;
        hp;
        s = sda_in;
        scl_out <= 1'b0;
        hp;
    endtask
    // Frame boundaries: data falls or rises while the clock is high
    task automatic start;
        hp;
        sda_out <= 1'b0;
        hp;
        scl_out <= 1'b0;
        hp;
    endtask
    task automatic stop;
        sda_out <= 1'b0;
        hp;
        scl_out <= 1'b1;
        hp;
        sda_out <= 1'b1;
        hp;
    endtask
    // Byte MSB first, ninth slot released; reports ack or read byte
    task automatic xb(input logic [7:0] b, input logic rd);
        logic [7:0] d;
        logic       s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i] | rd, s);
            d[i] = s;
        end
        bit_io(1'b1, s);
        res_d_out <= rd ? d : {7'h00, ~s};
        res_v_out <= 1'b1;
        @(posedge clk_in);
        res_v_out <= 1'b0;
    endtask
    // Single update: address, register byte, data byte
    task automatic wr_reg(input logic [6:0] a, input logic [7:0] r,
                          input logic [7:0] d);
        start;
        xb({a, 1'b0}, 1'b0);
        xb(r, 1'b0);
        xb(d, 1'b0);
        stop;
    endtask
    // Pointer set, then one byte read and refused with a high ninth bit
    task automatic rd_reg(input logic [6:0] a, input logic [7:0] r);
        start;
        xb({a, 1'b0}, 1'b0);
        xb(r, 1'b0);
        stop;
        start;
        xb({a, 1'b1}, 1'b0);
        xb(8'hFF, 1'b1);
        stop;
    endtask
endmodule
`default_nettype wire

/* testbench/tbc_regs_monitor.sv */
// Concurrent checks on the ports of the regulator register block
`timescale 1ns/1ps
`default_nettype none
module tbc_regs_monitor (
    input wire logic       clk_in,                   // System clock
    input wire logic       srst_in,                  // Synchronous reset
    input wire logic       scl_in,                   // Serial clock level
    input wire logic       sda_oe_out,               // Data pull-down
    input wire logic       sw_tick_in,               // Switching pulse
    input wire logic       converter1_hw_enable_pin, // Hardware enable 1
    input wire logic       converter2_hw_enable_pin, // Hardware enable 2
    input wire logic       converter3_hw_enable_pin, // Hardware enable 3
    input wire logic [2:0] light_load_out,           // Pulse-skipping bits
    input wire logic [2:0] disable_n_out,            // Disable bits
    input wire logic       vid_active_out,           // Apply bit
    input wire logic [6:0] vid_code_out,             // Applied code
    input wire logic       vid_busy_out              // Walk running
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    // Control outputs, the code walk and the data line driver
    a_reset_clears_outputs: assert property (
        $fell(srst_in) |-> !vid_active_out && vid_code_out == 7'h00
            && light_load_out == 3'h0 && disable_n_out == 3'h0)
        else $error("control outputs not clear after reset");
    a_code_holds_idle: assert property (
        !vid_active_out |=> $stable(vid_code_out))
        else $error("applied code moved while apply bit is low");
    a_code_single_step: assert property (
        $changed(vid_code_out) |-> vid_code_out == $past(vid_code_out) + 7'h01
            || vid_code_out == $past(vid_code_out) - 7'h01)
        else $error("applied code jumped by more than one count");
    a_step_after_tick: assert property (
        $changed(vid_code_out) |-> $past(sw_tick_in) || $past(sw_tick_in, 2))
        else $error("applied code moved without a switching pulse");
    a_step_only_busy: assert property (
        $changed(vid_code_out) |-> $past(vid_busy_out))
        else $error("applied code moved with no transition running");
    a_ack_stands_high: assert property (
        scl_in && $past(scl_in) |-> $stable(sda_oe_out))
        else $error("data line drive changed while serial clock high");
    a_hw_off_locked: assert property (
        $changed({light_load_out, disable_n_out, vid_active_out})
            |-> $past(converter1_hw_enable_pin || converter2_hw_enable_pin
            || converter3_hw_enable_pin))
        else $error("register updated while all hardware enables low");
    a_update_scl_low: assert property (
        $changed({light_load_out, disable_n_out}) |-> !scl_in)
        else $error("register updated while serial clock high");
endmodule
bind tbc_regs tbc_regs_monitor i_mon (
    .clk_in(clk_in), .srst_in(srst_in), .scl_in(scl_in),
    .sda_oe_out(sda_oe_out), .sw_tick_in(sw_tick_in),
    .converter1_hw_enable_pin(converter1_hw_enable_pin),
    .converter2_hw_enable_pin(converter2_hw_enable_pin),
    .converter3_hw_enable_pin(converter3_hw_enable_pin),
    .light_load_out(light_load_out), .disable_n_out(disable_n_out),
    .vid_active_out(vid_active_out), .vid_code_out(vid_code_out),
    .vid_busy_out(vid_busy_out)
);
`default_nettype wire

/* testbench/triple_buck_control_registers_tb_top.sv */
// Self-checking bench of the regulator control registers
`timescale 1ns/1ps
`default_nettype none
module triple_buck_control_registers_tb_top;
    localparam logic [6:0] TA = 7'h2A;   // Bus address, arbitrary value
    localparam logic [6:0] BAD [3] = '{TA ^ 7'h01, 7'h00, 7'h79};
    logic        clk_in, srst_in, tick, ot, tw, act, busy, scl, hsda, oe;
    logic        res_v;                  // Host result strobe
    logic [2:0]  en, ov, ir, ll, dn;     // Pins and command bits
    logic [7:0]  res_d, d, cm [3];       // Results and written values
    logic [6:0]  code, prev_code, tgt;   // Applied and target codes
    logic [8:0]  e, q [$];               // Expected results, bit 8 ignore
    logic [1:0]  tcnt;                   // Switching cycle divider
    logic [31:0] rs, v;                  // Random state and draw
    int          errors, n_compared, gap, tk;
    wire         sda = hsda & ~oe;       // Pulled-up wired-AND data line
    tbc_regs #(.TARGET_ADDR(TA)) i_dut (
        .clk_in(clk_in), .srst_in(srst_in), .scl_in(scl), .sda_in(sda),
        .sda_out(), .sda_oe_out(oe), .sw_tick_in(tick),
        .converter1_hw_enable_pin(en[0]), .converter2_hw_enable_pin(en[1]),
        .converter3_hw_enable_pin(en[2]), .over_temp_in(ot),
        .thermal_warn_in(tw), .overload_in(ov), .in_range_in(ir),
        .light_load_out(ll), .disable_n_out(dn), .vid_active_out(act),
        .vid_code_out(code), .vid_busy_out(busy));
    tbc_host_model i_host (.clk_in(clk_in), .sda_in(sda), .scl_out(scl),
        .sda_out(hsda), .res_v_out(res_v), .res_d_out(res_d));
    // Clock and one switching pulse every fourth cycle
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        tcnt <= tcnt + 2'd1;
        tick <= (tcnt == 2'd3);
    end
    // Pulses between the last two code steps
    always @(negedge clk_in) begin
        if (code !== prev_code) begin
            gap = tk;
            tk = 0;
            prev_code = code;
        end
        if (tick === 1'b1) tk = tk + 1;
    end
    // Each host result is matched with the oldest note
    always @(posedge clk_in) begin
        if (res_v === 1'b1) begin
            e = q.pop_front();
            if (!e[8]) check(res_d, e[7:0]);
        end
    end
    function automatic logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        n_compared++;
        if (seen !== want) begin
            errors++;
            $display("wrong value at %0t ns: %h not %h", $time, seen, want);
        end
    endtask
    // Write with expected acks: foreign addresses get none
    task automatic wr(input logic [6:0] a, input logic [7:0] r,
                      input logic [7:0] dv, input logic [8:0] dack);
        q.push_back({8'h00, a == TA});
        q.push_back({8'h00, a == TA});
        q.push_back(dack);
        i_host.wr_reg(a, r, dv);
    endtask
    task automatic rd(input logic [7:0] r, input logic [7:0] dv);
        repeat (3) q.push_back(9'h001);
        q.push_back({1'b0, dv});
        i_host.rd_reg(TA, r);
    endtask
    task automatic settle;
        for (int n = 0; n < 8000 && busy !== 1'b0; n++) @(posedge clk_in);
        @(negedge clk_in);
    endtask
    task automatic conclude;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Cuts a hang short, well past the roughly 35k cycles of the tests
    initial begin
        repeat (90000) @(posedge clk_in);
        errors++;
        conclude;
    end
    // Main sequence
    initial begin
        rs = 32'd53637;
        {errors, n_compared, tk} = '0;
        {srst_in, en, ot, tw, ov, ir, tcnt, tick} = 15'h7800;
        prev_code = 7'h00;
        repeat (6) @(posedge clk_in);
        srst_in <= 1'b0;
        @(posedge clk_in);
        for (int i = 1; i < 7; i++) rd(i[7:0], 8'h00);
        $display("test reset values finished");
        for (int k = 0; k < 4; k++) begin
            for (int i = 0; i < 3; i++) begin
                v = xs();
                d = {v[7:2], k[1:0]};
                cm[i] = d;
                wr(TA, 8'h03 + i[7:0], d, 9'h001);
                rd(8'h03 + i[7:0], d);
            end
            @(negedge clk_in);
            check({5'h0, ll}, {5'h0, cm[2][1], cm[1][1], cm[0][1]});
            check({5'h0, dn}, {5'h0, cm[2][0], cm[1][0], cm[0][0]});
        end
        $display("test command registers finished");
        for (int k = 0; k < 4; k++) begin
            v = xs();
            @(posedge clk_in);
            {ot, ov, tw, ir} <= v[7:0];
            wr(TA, 8'h06, ~v[7:0], 9'h100);
            rd(8'h06, v[7:0]);
        end
        $display("test status finished");
        foreach (BAD[j]) wr(BAD[j], 8'h03, ~cm[0], 9'h000);
        @(posedge clk_in);
        en <= 3'b000;
        wr(TA, 8'h03, ~cm[0], 9'h001);
        @(posedge clk_in);
        en <= 3'b111;
        rd(8'h03, cm[0]);
        $display("test refusals finished");
        for (int n = 0; n < 8; n++) begin
            tgt = 7'(n * 9 + 3);
            wr(TA, 8'h04, {1'b0, n[2:0], 4'h0}, 9'h001);
            wr(TA, 8'h01, {1'b1, tgt}, 9'h001);
            settle;
            check({act, code}, {1'b1, tgt});
            check(gap[7:0], 8'd1 << n);
        end
        wr(TA, 8'h01, 8'h10, 9'h001);
        repeat (300) @(posedge clk_in);
        check({act, code}, {1'b0, tgt});
        wr(TA, 8'h04, 8'h00, 9'h001);
        wr(TA, 8'h01, 8'hFF, 9'h001);
        settle;
        check({act, code}, 8'hFF);
        wr(TA, 8'h01, 8'h81, 9'h001);
        settle;
        check({act, code}, 8'h81);
        $display("test voltage walk finished");
        repeat (4) @(posedge clk_in);
        conclude;
    end
endmodule
`default_nettype wire

/* verilog/tbc_regs.v */
// Two-wire target interface and control/status registers of the regulator
`timescale 1ns/1ps
`default_nettype none
`include "tbc_defines.vh"

module tbc_regs #(
    parameter [6:0] TARGET_ADDR = 7'h2A       // Bus address, arbitrary value
) (
    input  wire       clk_in,                 // 50 MHz clock
    input  wire       srst_in,                // Synchronous reset
    input  wire       scl_in,                 // Serial clock level
    input  wire       sda_in,                 // Serial data level
    output wire       sda_out,                // Serial data drive value
    output wire       sda_oe_out,             // High while pulling data low
    input  wire       sw_tick_in,             // Switching cycle pulse
    input  wire       converter1_hw_enable_pin, // Hardware enable 1
    input  wire       converter2_hw_enable_pin, // Hardware enable 2
    input  wire       converter3_hw_enable_pin, // Hardware enable 3
    input  wire       over_temp_in,           // Above 160 C, protection on
    input  wire       thermal_warn_in,        // Above 125 C
    input  wire [2:0] overload_in,            // Hiccup per converter 3..1
    input  wire [2:0] in_range_in,            // Power-good per output 3..1
    output wire [2:0] light_load_out,         // Pulse-skipping per converter
    output wire [2:0] disable_n_out,          // Active-low disable bits 3..1
    output wire       vid_active_out,         // Programmed code in use
    output wire [6:0] vid_code_out,           // Applied code 0.68 V + 10 mV*n
    output wire       vid_busy_out            // Code transition running
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg [7:0] vsel_reg;
    reg [7:0] cmd1_reg;
    reg [7:0] cmd2_reg;
    reg [7:0] cmd3_reg;
    reg [7:0] status_reg;

    // ------------------------------------------------------------
    // Serial bus edge and condition detection
    // ------------------------------------------------------------
    reg scl_d_reg;
    reg sda_d_reg;
    wire scl_rise = scl_in && !scl_d_reg;
    wire scl_fall = !scl_in && scl_d_reg;
    wire start_c  = scl_in && scl_d_reg && sda_d_reg && !sda_in;
    wire stop_c   = scl_in && scl_d_reg && !sda_d_reg && sda_in;
    wire hw_off   = !converter1_hw_enable_pin && !converter2_hw_enable_pin
                    && !converter3_hw_enable_pin;

    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_ADDR = 5'h02;
    localparam [4:0] ST_REG  = 5'h04;
    localparam [4:0] ST_DATA = 5'h08;
    localparam [4:0] ST_READ = 5'h10;

    reg [4:0] state_reg;
    reg [4:0] state_next;
    reg [3:0] bit_reg;
    reg [3:0] bit_next;
    reg [7:0] shift_reg;
    reg [7:0] shift_next;
    reg [7:0] ptr_reg;
    reg [7:0] ptr_next;
    reg       ack_reg;
    reg       ack_next;
    reg       drive_reg;
    reg       drive_next;
    reg       wr_en;
    reg [7:0] rd_data;

    // Register read mux
    always @* begin
        case (ptr_reg)
            `TBC_ADDR_VSEL:   rd_data = vsel_reg;
            `TBC_ADDR_CMD1:   rd_data = cmd1_reg;
            `TBC_ADDR_CMD2:   rd_data = cmd2_reg;
            `TBC_ADDR_CMD3:   rd_data = cmd3_reg;
            `TBC_ADDR_STATUS: rd_data = status_reg;
            default:          rd_data = 8'h00;
        endcase
    end

    // Byte engine: address, register pointer, data
    always @* begin
        state_next = state_reg;
        bit_next   = bit_reg;
        shift_next = shift_reg;
        ptr_next   = ptr_reg;
        ack_next   = ack_reg;
        drive_next = drive_reg;
        wr_en      = 1'b0;
        if (start_c) begin
            state_next = ST_ADDR;
            bit_next   = 4'h0;
            ack_next   = 1'b0;
            drive_next = 1'b0;
        end else if (stop_c) begin
            state_next = ST_IDLE;
            ack_next   = 1'b0;
            drive_next = 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    ack_next = 1'b0;
                end
                ST_ADDR, ST_REG, ST_DATA, ST_READ: begin
                    if (scl_rise && bit_reg < 4'h8 && state_reg != ST_READ) begin
                        shift_next = {shift_reg[6:0], sda_in};
                        bit_next   = bit_reg + 4'h1;
                    end else if (scl_fall && bit_reg == 4'h8 && !ack_reg) begin
                        // Ninth clock: decide on acknowledge
                        ack_next = 1'b0;
                        drive_next = 1'b0;
                        case (state_reg)
                            ST_ADDR: begin
                                if (shift_reg[7:1] == TARGET_ADDR
                                    && shift_reg[7:1] != `TBC_GCALL_ADDR
                                    && shift_reg[7:3] != `TBC_TENBIT_PFX) begin
                                    ack_next = 1'b1;
                                    if (shift_reg[0]) begin
                                        state_next = ST_READ;
                                    end else begin
                                        state_next = ST_REG;
                                    end
                                end else begin
                                    state_next = ST_IDLE;
                                end
                            end
                            ST_REG: begin
                                ptr_next = shift_reg;
                                ack_next = 1'b1;
                                state_next = ST_DATA;
                            end
                            ST_DATA: begin
                                wr_en    = !hw_off;
                                ack_next = 1'b1;
                            end
                            default: begin
                                state_next = ST_IDLE;
                            end
                        endcase
                    end else if (scl_fall && ack_reg) begin
                        // Acknowledge clock over
                        ack_next = 1'b0;
                        bit_next = 4'h0;
                        if (state_reg == ST_READ) begin
                            shift_next = rd_data;
                            drive_next = !rd_data[7];
                            bit_next   = 4'h9;
                        end
                    end else if (state_reg == ST_READ && scl_fall) begin
                        // Counts 9..15 show bits 7..1, the wrap to 0 shows
                        // bit 0; the fall after bit 0 frees the line
                        if (bit_reg == 4'h0) begin
                            drive_next = 1'b0;
                            state_next = ST_IDLE;
                        end else begin
                            shift_next = {shift_reg[6:0], 1'b1};
                            drive_next = !shift_reg[6];
                            bit_next   = bit_reg + 4'h1;
                        end
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                end
            endcase
        end
    end

    assign sda_out    = 1'b0;
    assign sda_oe_out = ack_reg || drive_reg;

    // Engine state and control registers
    always @(posedge clk_in) begin
        if (srst_in) begin
            scl_d_reg  <= 1'b1;
            sda_d_reg  <= 1'b1;
            state_reg  <= ST_IDLE;
            bit_reg    <= 4'h0;
            shift_reg  <= 8'h00;
            ptr_reg    <= 8'h00;
            ack_reg    <= 1'b0;
            drive_reg  <= 1'b0;
            vsel_reg   <= `TBC_REG_RESET;
            cmd1_reg   <= `TBC_REG_RESET;
            cmd2_reg   <= `TBC_REG_RESET;
            cmd3_reg   <= `TBC_REG_RESET;
            status_reg <= `TBC_REG_RESET;
        end else begin
            scl_d_reg  <= scl_in;
            sda_d_reg  <= sda_in;
            state_reg  <= state_next;
            bit_reg    <= bit_next;
            shift_reg  <= shift_next;
            ptr_reg    <= ptr_next;
            ack_reg    <= ack_next;
            drive_reg  <= drive_next;
            // Live status, writes never reach it
            status_reg <= {over_temp_in,
                           overload_in,
                           thermal_warn_in,
                           in_range_in};
            if (wr_en) begin
                case (ptr_reg)
                    `TBC_ADDR_VSEL: vsel_reg <= shift_reg;
                    `TBC_ADDR_CMD1: cmd1_reg <= shift_reg;
                    `TBC_ADDR_CMD2: cmd2_reg <= shift_reg;
                    `TBC_ADDR_CMD3: cmd3_reg <= shift_reg;
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Converter controls
    // ------------------------------------------------------------
    assign light_load_out = {cmd3_reg[`TBC_MODE_BIT],
                             cmd2_reg[`TBC_MODE_BIT],
                             cmd1_reg[`TBC_MODE_BIT]};
    assign disable_n_out  = {cmd3_reg[`TBC_DIS_N_BIT],
                             cmd2_reg[`TBC_DIS_N_BIT],
                             cmd1_reg[`TBC_DIS_N_BIT]};
    assign vid_active_out = vsel_reg[`TBC_APPLY_BIT];

    // Code n means 0.68 V plus n times 10 mV
    tbc_slew_stepper #(
        .CODE_W    (7)
    ) u_step (
        .clk_in    (clk_in),
        .srst_in   (srst_in),
        .sw_tick_in(sw_tick_in),
        .go_in     (vsel_reg[`TBC_APPLY_BIT]),
        .target_in (vsel_reg[`TBC_CODE_MSB:0]),
        .slew_in   (cmd2_reg[`TBC_SLEW_MSB:`TBC_SLEW_LSB]),
        .code_out  (vid_code_out),
        .busy_out  (vid_busy_out)
    );

endmodule
`default_nettype wire

/* verilog/tbc_slew_stepper.v */
// Slew-limited stepper of the applied converter-2 voltage code
`timescale 1ns/1ps
`default_nettype none
`include "tbc_defines.vh"

module tbc_slew_stepper #(
    parameter CODE_W = 7                     // Voltage code width
) (
    input  wire              clk_in,          // System clock
    input  wire              srst_in,         // Synchronous reset
    input  wire              sw_tick_in,      // One pulse per switching cycle
    input  wire              go_in,           // Apply bit
    input  wire [CODE_W-1:0] target_in,       // Programmed code
    input  wire [2:0]        slew_in,         // Slew exponent N
    output reg  [CODE_W-1:0] code_out,        // Applied code
    output wire              busy_out         // Transition in progress
);

    reg [7:0] wait_reg;
    reg [7:0] wait_next;
    reg [CODE_W-1:0] code_next;
    wire [7:0] period = 8'h01 << slew_in;     // 2^N cycles per step

    assign busy_out = go_in && (code_out != target_in);

    // Step one count per 2^N switching cycles toward the target
    always @* begin
        wait_next = wait_reg;
        code_next = code_out;
        if (!busy_out) begin
            wait_next = 8'h00;
        end else if (sw_tick_in) begin
            if (wait_reg + 8'h01 >= period) begin
                wait_next = 8'h00;
                if (code_out < target_in) begin
                    code_next = code_out + 1'b1;
                end else begin
                    code_next = code_out - 1'b1;
                end
            end else begin
                wait_next = wait_reg + 8'h01;
            end
        end
    end

    // State registers
    always @(posedge clk_in) begin
        if (srst_in) begin
            wait_reg <= 8'h00;
            code_out <= {CODE_W{1'b0}};
        end else begin
            wait_reg <= wait_next;
            code_out <= code_next;
        end
    end

endmodule
`default_nettype wire
